// [core/bmc_board_memory_control.sv]
// board memory controller top: sram, dram and byte rom paths
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
module bmc_board_memory_control
    import bmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic cpuReq,
    input wire logic cpuSeq,
    input wire logic cpuWrite,
    input wire logic [31:0] cpuAddr,
    input wire logic [3:0] cpuByteEn,
    output logic cpuWait,
    output logic [31:0] cpuRdata,
    output logic sramCe_n,
    output logic sramOe_n,
    output logic sramAdsc_n,
    output logic sramAdv_n,
    output logic sramBwe_n,
    output logic sramMode,
    output logic [1:0] dramRas_n,
    output logic [3:0] dramCas_n,
    output logic dramWe_n,
    output logic [11:0] dramAddr,
    input wire logic [2:1] simm_size_code,
    output logic romEprCe_n,
    output logic romFlsCe_n,
    output logic romOe_n,
    output logic romWe_n,
    output logic [1:0] romAddrLow,
    input wire logic [7:0] romData,
    input wire logic epromBoot_n
);
    bmc_axil_if regs();
    bmc_axil_slave u_slave (
        .core_clk(core_clk), .rstn(rstn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .regs(regs)
    );

    function automatic logic [1:0] rasSelect(input logic [2:1] code, input logic [31:0] a);
        // larger modules push the bank bit upward
        case (code)
            2'h0: rasSelect = a[22] ? 2'h2 : 2'h1;
            2'h1: rasSelect = a[24] ? 2'h2 : 2'h1;
            2'h2: rasSelect = a[23] ? 2'h2 : 2'h1;
            default: rasSelect = a[25] ? 2'h2 : 2'h1;
        endcase
    endfunction

    typedef struct packed {
        logic bootMap;
        bmc_dram_t dr;
        logic burstLive;
        logic [1:0] rasOn;
        logic [3:0] casOn;
        logic weOn;
        logic [11:0] dAddr;
        logic cfgPend;
        logic sramRd;
        logic sramPipe;
        logic romBusy;
        logic romWr;
        logic [1:0] romCnt;
        logic [2:0] romTick;
        logic [23:0] romPack;
        logic [31:0] rdData;
        logic done;
        logic romSelFls;
    } bmc_core_t;
    bmc_core_t st, next_st;

    logic [1:0] quad;
    logic isRom, isSram, isDram, lowHalf, selFls;
    assign quad = cpuAddr[31:30];
    // after reset the boot quadrant aliases rom so first fetches land there
    assign isRom = (quad == QUAD_ROM) || (st.bootMap && quad == QUAD_BOOT);
    assign isSram = (quad == QUAD_SRAM);
    assign isDram = (quad == QUAD_DRAM);
    assign lowHalf = !cpuAddr[29];
    assign selFls = lowHalf ? epromBoot_n : !epromBoot_n;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (regs.bootClear) begin
            next_st.bootMap = 1'b0;
        end
        if (regs.cfgPulse) begin
            next_st.cfgPend = 1'b1;
        end
        // sram: data valid the cycle after the address is sampled
        next_st.sramPipe = st.sramRd;
        next_st.sramRd = cpuReq && isSram && !cpuWrite;
        if (st.sramPipe) begin
            next_st.done = 1'b1;
        end
        if (cpuReq && isSram && cpuWrite) begin
            next_st.done = 1'b1;
        end
        case (st.dr)
            DR_IDLE: begin
                next_st.casOn = 4'h0;
                next_st.rasOn = 2'h0;
                next_st.weOn = 1'b0;
                if (st.cfgPend) begin
                    // write cbr: column strobes first, write asserted
                    next_st.casOn = 4'hF;
                    next_st.weOn = 1'b1;
                    next_st.dAddr = {11'h000, regs.interleave};
                    next_st.dr = DR_CBR;
                end else if (cpuReq && isDram) begin
                    next_st.rasOn = rasSelect(simm_size_code, cpuAddr);
                    next_st.dAddr = cpuAddr[ROW_LSB +: 12];
                    next_st.dr = DR_ROW;
                end
            end
            DR_CBR: begin
                next_st.rasOn = 2'h3;
                next_st.cfgPend = regs.cfgPulse;
                next_st.dr = DR_PRE;
            end
            DR_ROW: begin
                next_st.dAddr = {2'h0, cpuAddr[11:2]};
                next_st.weOn = cpuWrite;
                next_st.casOn = cpuWrite ? cpuByteEn : 4'hF;
                next_st.burstLive = regs.bedoSel;
                next_st.done = 1'b1;
                next_st.dr = DR_COL;
            end
            DR_COL: begin
                if (st.done) begin
                    // request seen now is the one just answered: wait for the next
                    // edo keeps data after strobe negation, so release early
                    next_st.casOn = (regs.bedoSel && st.burstLive) ? st.casOn : 4'h0;
                end else if (cpuReq && cpuSeq && isDram) begin
                    // page mode within the open row
                    next_st.done = 1'b1;
                    next_st.dAddr = {2'h0, cpuAddr[11:2]};
                    next_st.weOn = cpuWrite;
                    next_st.casOn = cpuWrite ? cpuByteEn : 4'hF;
                    if (regs.bedoSel && st.burstLive) begin
                        // burst edo counter runs on; hold strobe asserted instead
                        next_st.casOn = 4'hF;
                    end
                end else begin
                    next_st.casOn = 4'h0;
                    // burst edo: a write-type strobe ends the burst first
                    next_st.weOn = regs.bedoSel && st.burstLive;
                    next_st.rasOn = 2'h0;
                    next_st.burstLive = 1'b0;
                    next_st.dr = DR_PRE;
                end
            end
            DR_PRE: begin
                next_st.rasOn = 2'h0;
                next_st.casOn = 4'h0;
                next_st.weOn = 1'b0;
                next_st.dr = DR_IDLE;
            end
            default: next_st.dr = DR_IDLE;
        endcase
        if (!st.romBusy) begin
            if (cpuReq && isRom && !st.done) begin
                next_st.romBusy = 1'b1;
                next_st.romWr = cpuWrite;
                next_st.romSelFls = selFls;
                next_st.romTick = ROM_WAIT;
                // flash writes take their byte offset from high address bits
                next_st.romCnt = cpuWrite ? cpuAddr[FLASH_OFS_LSB +: 2] : 2'h0;
            end
        end else if (st.romTick != 3'h0) begin
            next_st.romTick = st.romTick - 3'h1;
        end else if (st.romWr) begin
            next_st.romBusy = 1'b0;
            next_st.done = 1'b1;
        end else begin
            next_st.romCnt = st.romCnt + 2'h1;
            next_st.romTick = ROM_WAIT;
            case (st.romCnt)
                2'h0: next_st.romPack[7:0] = romData;
                2'h1: next_st.romPack[15:8] = romData;
                2'h2: next_st.romPack[23:16] = romData;
                default: begin
                    next_st.rdData = {romData, st.romPack};
                    next_st.romBusy = 1'b0;
                    next_st.done = 1'b1;
                end
            endcase
        end
        if (st.dr == DR_ROW) begin
            next_st.rdData = next_st.rdData;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.bootMap <= 1'b1;
            st.dr <= DR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // sram control: address strobe on every cycle with cpuReq high so each address is a read start
    assign sramCe_n = 1'b0;
    assign sramAdsc_n = !cpuReq;
    assign sramOe_n = !(st.sramRd || st.sramPipe);
    assign sramAdv_n = !(cpuReq && cpuSeq && isSram);
    assign sramBwe_n = !(cpuReq && isSram && cpuWrite);
    assign sramMode = 1'b0;
    assign dramRas_n = ~st.rasOn;
    assign dramCas_n = ~st.casOn;
    assign dramWe_n = !st.weOn;
    assign dramAddr = st.dAddr;
    assign romEprCe_n = !(st.romBusy && !st.romSelFls);
    assign romFlsCe_n = !(st.romBusy && st.romSelFls);
    assign romOe_n = !(st.romBusy && !st.romWr);
    assign romWe_n = !(st.romBusy && st.romWr && st.romTick != 3'h0);
    assign romAddrLow = st.romCnt;
    assign cpuRdata = st.rdData;
    // sram writes complete in the cycle they are presented
    assign cpuWait = cpuReq && !st.done && !(isSram && cpuWrite);
    assign regs.status = {2'h0, st.bootMap, st.cfgPend, st.romBusy, st.romCnt,
        st.dr != DR_IDLE};

    property p_rom_pack_wait;
        @(posedge core_clk) disable iff (!rstn)
        $rose(st.romBusy) && !st.romWr |-> !st.done [*8];
    endproperty
    a_rom_pack_wait: assert property (p_rom_pack_wait) else $error("rom done early");
    property p_cnt_wrap;
        @(posedge core_clk) disable iff (!rstn)
        st.romBusy && !st.romWr && st.romTick == 3'h0 |=> romAddrLow == $past(romAddrLow) + 2'h1;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap) else $error("byte counter step");
    property p_sram_pipe;
        @(posedge core_clk) disable iff (!rstn)
        cpuReq && isSram && !cpuWrite |-> ##3 st.done;
    endproperty
    a_sram_pipe: assert property (p_sram_pipe) else $error("sram data timing");
    property p_mode_low;
        @(posedge core_clk) disable iff (!rstn) !sramMode && !sramCe_n;
    endproperty
    a_mode_low: assert property (p_mode_low) else $error("sram mode or ce");
    property p_page_close;
        @(posedge core_clk) disable iff (!rstn)
        st.dr == DR_COL && !st.done && !(cpuReq && cpuSeq && isDram) |=> dramRas_n == 2'h3;
    endproperty
    a_page_close: assert property (p_page_close) else $error("page left open");
    property p_ras_one;
        @(posedge core_clk) disable iff (!rstn)
        st.dr == DR_IDLE && !st.cfgPend && cpuReq && isDram |=> $countones(dramRas_n) == 1;
    endproperty
    a_ras_one: assert property (p_ras_one) else $error("row select decode");
    property p_flash_jam;
        @(posedge core_clk) disable iff (!rstn)
        !st.romBusy && cpuReq && isRom && cpuWrite && !st.done
        |=> romAddrLow == $past(cpuAddr[23:22]);
    endproperty
    a_flash_jam: assert property (p_flash_jam) else $error("flash offset load");
    sequence s_cbr_start;
        st.dr == DR_CBR && dramCas_n == 4'h0 && !dramWe_n;
    endsequence
    property p_cbr;
        @(posedge core_clk) disable iff (!rstn)
        s_cbr_start |=> dramRas_n == 2'h0 ##1 dramRas_n == 2'h3;
    endproperty
    a_cbr: assert property (p_cbr) else $error("cbr order");
endmodule

// [core/bmc_pkg.sv]
// constants and types for the board memory controller
// Behaviour
// - sram read data one cycle after address
// - sram controls timed on inverted bus clock
// - hold sram wrap mode negated, linear
// - every burst start explicitly loaded, reload anytime
// - oe, ce, strobe run access; advance; byte writes
// - never powerdown; latch every presented address
// - select input alters dram state transitions
// - burst edo: stop burst before new address
// - wrap mode set by write cbr cycle
// - burst edo uses only row, column, write
// - sequential cycles are page mode accesses
// - row address starts at bit twelve
// - close page when sequential access ends
// - byte enables qualify four column strobes; code: on writes only, all four asserted on reads and in burst edo page cycles
// - row selects decoded by simm size code
// - rom in quadrant 10, plus 00 after reset
// - boot jumper picks rom in lower half
// - 2-bit counter addresses, packs four rom bytes
// - flash write loads counter from a[23:22]
// - logic clocked by inverted bus clock
// - held in reset by processor reset
package bmc_pkg;
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam int CTRL_BURST_EDO_BIT = 0;
    localparam int CTRL_INTLV_BIT = 1;
    localparam int CTRL_CFG_BIT = 2;
    localparam int CTRL_BOOTCLR_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int ROW_LSB = 12;
    localparam int FLASH_OFS_LSB = 22;
    localparam logic [1:0] QUAD_ROM = 2'h2;
    localparam logic [1:0] QUAD_BOOT = 2'h0;
    localparam logic [1:0] QUAD_DRAM = 2'h1;
    localparam logic [1:0] QUAD_SRAM = 2'h3;
    localparam logic [2:0] ROM_WAIT = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum {DR_IDLE, DR_ROW, DR_COL, DR_PRE, DR_CBR} bmc_dram_t;
endpackage

// [core/bmc_axil_if.sv]
// register side signals between the bus slave and the controller
interface bmc_axil_if;
    logic bedoSel;
    logic interleave;
    logic cfgPulse;
    logic bootClear;
    logic [7:0] status;
    modport slave (output bedoSel, output interleave, output cfgPulse, output bootClear,
        input status);
    modport core (input bedoSel, input interleave, input cfgPulse, input bootClear,
        output status);
endinterface

// [core/bmc_axil_slave.sv]
// axi4-lite register slave for the memory controller
module bmc_axil_slave
    import bmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    bmc_axil_if.slave regs
);
    typedef struct packed {
        logic awHeld;
        logic [31:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [3:0] ctrl;
        logic cfgPulse;
    } bmc_axs_t;
    bmc_axs_t st, next_st;
    always_comb begin
        next_st = st;
        next_st.cfgPulse = 1'b0;
        if (awvalid && awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata;
            next_st.wLane0 = wstrb[0];
        end
        if (st.awHeld && st.wHeld && !st.bValid) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = RESP_OKAY;
            if (st.awAddr[31:2] == REG_CTRL[31:2]) begin
                if (st.wLane0) begin
                    next_st.ctrl = st.wData[3:0];
                    next_st.cfgPulse = st.wData[CTRL_CFG_BIT];
                end
            end else if (st.awAddr[31:2] != REG_STATUS[31:2]) begin
                next_st.bResp = RESP_SLVERR;
            end
        end
        if (st.bValid && bready) begin
            next_st.bValid = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rValid = 1'b1;
            next_st.rResp = RESP_OKAY;
            if (araddr[31:2] == REG_CTRL[31:2]) begin
                next_st.rData = {28'h0000000, st.ctrl};
            end else if (araddr[31:2] == REG_STATUS[31:2]) begin
                next_st.rData = {24'h000000, regs.status};
            end else begin
                next_st.rData = 32'h0000_0000;
                next_st.rResp = RESP_SLVERR;
            end
        end else if (st.rValid && rready) begin
            next_st.rValid = 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign awready = !st.awHeld;
    assign wready = !st.wHeld;
    assign bvalid = st.bValid;
    assign bresp = st.bResp;
    assign arready = !st.rValid;
    assign rvalid = st.rValid;
    assign rdata = st.rData;
    assign rresp = st.rResp;
    assign regs.bedoSel = st.ctrl[CTRL_BURST_EDO_BIT];
    assign regs.interleave = st.ctrl[CTRL_INTLV_BIT];
    assign regs.bootClear = st.ctrl[CTRL_BOOTCLR_BIT];
    assign regs.cfgPulse = st.cfgPulse;
endmodule

// [tb/bmc_rom_model.sv]
// byte wide eprom and flash pair on the far side of the controller
module bmc_rom_model (
    input wire logic core_clk,
    input wire logic romEprCe_n,
    input wire logic romFlsCe_n,
    input wire logic romOe_n,
    input wire logic romWe_n,
    input wire logic [1:0] romAddrLow,
    output logic [7:0] romData,
    output logic [1:0] wrAddr,
    output logic wrFlash
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle = 1'b0;
    always @(posedge core_clk) begin
        toggle <= ~toggle;
    end
    // released bus shows a moving pattern, so stale bytes cannot pass as good
    always_comb begin
        if (!romOe_n && !romEprCe_n) begin
            romData = 8'hE0 | {6'h00, romAddrLow};
        end else if (!romOe_n && !romFlsCe_n) begin
            romData = 8'hF0 | {6'h00, romAddrLow};
        end else begin
            romData = toggle ? 8'hA5 : 8'h5A;
        end
    end
    // remember where the last strobed byte write landed
    always @(posedge core_clk) begin
        if (!romWe_n) begin
            wrAddr <= romAddrLow;
            wrFlash <= !romFlsCe_n;
        end
    end
endmodule

// [tb/bmc_board_memory_control_tb_top.sv]
// self-checking bench for the board memory controller
module bmc_board_memory_control_tb_top
    import bmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn = 0, awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0, cpuReq = 0, cpuSeq = 0, cpuWrite = 0;
    logic sramCe_n, sramOe_n, sramAdsc_n, sramAdv_n, sramBwe_n, sramMode, dramWe_n, cpuWait;
    logic romEprCe_n, romFlsCe_n, romOe_n, romWe_n, epromBoot_n = 1, wrFlash;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, cpuAddr = 0, rdata, cpuRdata, got;
    logic [3:0] wstrb = 4'hF, cpuByteEn = 4'hF, dramCas_n, casLow;
    logic [1:0] bresp, rresp, dramRas_n, simm_size_code = 0, romAddrLow, wrAddr, resp;
    logic [1:0] rasLow, rasPrev = 2'h3;
    logic [11:0] dramAddr, rowSeen;
    logic [7:0] romData;
    logic weLow, adscLow, oeLow, bweLow;
    int errors = 0, n_tests = 0, waits, rasFalls;

    bmc_board_memory_control bmc_board_memory_control_i (
        .core_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .cpuReq, .cpuSeq, .cpuWrite, .cpuAddr, .cpuByteEn, .cpuWait, .cpuRdata,
        .sramCe_n, .sramOe_n, .sramAdsc_n, .sramAdv_n, .sramBwe_n, .sramMode, .dramRas_n,
        .dramCas_n, .dramWe_n, .dramAddr, .simm_size_code, .romEprCe_n, .romFlsCe_n,
        .romOe_n, .romWe_n, .romAddrLow, .romData, .epromBoot_n
    );
    bmc_rom_model bmc_rom_model_i (
        .core_clk, .romEprCe_n, .romFlsCe_n, .romOe_n, .romWe_n, .romAddrLow, .romData,
        .wrAddr, .wrFlash
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // strobe activity seen since the last clear, sampled mid-cycle
    always @(negedge core_clk) begin
        if (rasLow == 2'b00 && dramRas_n != 2'b11) rowSeen = dramAddr;
        if (rasPrev == 2'b11 && dramRas_n != 2'b11) rasFalls++;
        rasPrev = dramRas_n;
        rasLow = rasLow | ~dramRas_n;
        casLow = casLow | ~dramCas_n;
        weLow = weLow | ~dramWe_n;
        adscLow = adscLow | ~sramAdsc_n;
        oeLow = oeLow | ~sramOe_n;
        bweLow = bweLow | ~sramBwe_n;
    end

    task automatic clr();
        rasLow = 0;
        casLow = 0;
        weLow = 0;
        adscLow = 0;
        oeLow = 0;
        bweLow = 0;
        rasFalls = 0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic endtest(input string s);
        $display("test %s done, %0d mismatches so far", s, errors);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // both channels offered together, each dropped once taken
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        int t;
        t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 100);
        resp = bresp;
        bready <= 1'b0;
        check(t < 100, 1, "write answered");
        @(posedge core_clk);
    endtask

    task automatic axr(input logic [31:0] a);
        int t;
        t = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 100);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        check(t < 100, 1, "read answered");
        @(posedge core_clk);
    endtask

    // keep leaves the request up so a sequential cycle can follow at once
    task automatic cpu(input logic wr, input logic sq, input logic [31:0] a,
        input logic [3:0] be, input logic keep);
        cpuReq <= 1'b1;
        cpuSeq <= sq;
        cpuWrite <= wr;
        cpuAddr <= a;
        cpuByteEn <= be;
        waits = 0;
        @(negedge core_clk);
        while (cpuWait === 1'b1 && waits < 400) begin
            waits++;
            @(negedge core_clk);
        end
        got = cpuRdata;
        check(waits < 400, 1, "cpu cycle completes");
        @(posedge core_clk);
        if (!keep) begin
            cpuReq <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    initial begin
        int bits[4];
        logic [31:0] a;
        bits = '{22, 24, 23, 25};
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        axr(REG_STATUS);
        check(got, 32'h0000_0020, "status after reset");
        axr(REG_CTRL);
        check(got, 32'h0000_0000, "ctrl after reset");
        check({sramCe_n, sramMode}, 2'b00, "sram enabled, linear wrap");
        axr(32'h0000_0100);
        check({resp, got}, {RESP_SLVERR, 32'h0}, "unmapped read");
        axw(32'h0000_0100, 32'h0000_000F);
        check(resp, RESP_SLVERR, "unmapped write");
        endtest("registers");
        cpu(1'b0, 1'b0, 32'h0000_0000, 4'hF, 1'b0);
        check(got, 32'hF3F2F1F0, "boot fetch packs flash");
        check(waits >= 12, 1, "held until four bytes");
        check(romAddrLow, 2'h0, "byte counter wrapped");
        epromBoot_n <= 1'b0;
        cpu(1'b0, 1'b0, 32'h8000_0000, 4'hF, 1'b0);
        check(got, 32'hE3E2E1E0, "lower half eprom");
        cpu(1'b0, 1'b0, 32'hA000_0000, 4'hF, 1'b0);
        check(got, 32'hF3F2F1F0, "upper half flash");
        epromBoot_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            cpu(1'b1, 1'b0, 32'h8000_0000 | (k << 22), 4'h1, 1'b0);
            check(wrAddr, k, "flash byte offset loaded");
            check(wrFlash, 1, "flash strobed");
        end
        endtest("rom");
        clr();
        cpu(1'b0, 1'b0, 32'hC000_0010, 4'hF, 1'b0);
        check(waits > 0, 1, "sram read pipelined");
        check({adscLow, oeLow}, 2'b11, "sram read strobes");
        cpu(1'b1, 1'b0, 32'hC000_0020, 4'h3, 1'b0);
        check(waits, 0, "sram write without wait");
        check(bweLow, 1, "sram byte write");
        endtest("sram");
        for (int c = 0; c < 4; c++) begin
            simm_size_code <= c[1:0];
            a = 32'h4000_0000 | (32'h1 << bits[c]);
            clr();
            cpu(1'b0, 1'b0, a, 4'hF, 1'b0);
            check(rasLow, 2'b10, "row select by simm size");
            check(rowSeen, a[23:12], "row from bit twelve");
            check(adscLow, 1, "address offered to sram");
            repeat (3) @(posedge core_clk);
            check(dramRas_n, 2'b11, "page closed");
        end
        clr();
        cpu(1'b1, 1'b0, 32'h4000_0000, 4'h2, 1'b0);
        check(casLow, 4'h2, "byte enables gate column strobes");
        check(weLow, 1, "dram write strobe");
        clr();
        cpu(1'b0, 1'b0, 32'h4000_0100, 4'hF, 1'b1);
        cpu(1'b0, 1'b1, 32'h4000_0104, 4'hF, 1'b0);
        check(rasFalls, 1, "sequential stays in page");
        endtest("dram edo");
        clr();
        axw(REG_CTRL, 32'h0000_0005);
        repeat (20) @(posedge core_clk);
        check({weLow, casLow}, 5'h1F, "write cbr configuration");
        axr(REG_CTRL);
        check(got & 32'h3, 32'h1, "burst edo selected");
        clr();
        cpu(1'b0, 1'b0, 32'h4000_0200, 4'hF, 1'b1);
        cpu(1'b0, 1'b1, 32'h4000_0204, 4'hF, 1'b1);
        cpu(1'b0, 1'b0, 32'h4000_0400, 4'hF, 1'b0);
        check(rasFalls, 2, "burst stopped before new row");
        endtest("dram burst edo");
        axw(REG_CTRL, 32'h0000_0008);
        axr(REG_STATUS);
        check(got & 32'h20, 32'h0, "boot alias cleared");
        endtest("boot alias");
        conclude();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule
